// File: design/mem_access_defines.svh
// constants for the data and program memory access decode block
`ifndef MEM_ACCESS_DEFINES_SVH
`define MEM_ACCESS_DEFINES_SVH

// ==========================================
// register offsets and values
`define ACC_SFR_AUX_HIGH 8'ha1
`define ACC_SFR_CHIP_CTRL 8'hbf
`define ACC_SFR_UNLOCK 8'hf6
`define ACC_UNLOCK_KEY1 8'h87
`define ACC_UNLOCK_KEY2 8'h59
`define ACC_UNLOCK_RELOCK 8'h00
`define ACC_CHIP_CTRL_RESET 8'h00
`define ACC_CHIP_CTRL_MASK 8'h9f
`define ACC_AUX_EN_BIT 4

// ==========================================
// address map
`define ACC_DIRECT_LIMIT 8'h80
`define ACC_AUX_LAST 16'h03ff
`define ACC_SCRATCH_WORDS 256
`define ACC_AUX_WORDS 1024

// ==========================================
// timing, in oscillator clocks except ACC_RESET_MCYCLES, in machine cycles
`define ACC_ALE_PERIOD 6
`define ACC_PHASE_LAST 3'((`ACC_ALE_PERIOD) - 1)
`define ACC_ALE_HIGH 3'h2
`define ACC_OSC_PER_MCYCLE 12
`define ACC_RESET_MCYCLES 2
`define ACC_RESET_HOLD 5'((`ACC_RESET_MCYCLES) * (`ACC_OSC_PER_MCYCLE))

`endif

// File: design/mem_access_pkg.sv
// types shared by the memory access decode block
package mem_access_pkg;

  typedef enum logic [2:0] {
    ACC_DIRECT = 3'h0,
    ACC_INDIRECT = 3'h1,
    ACC_XMOVE_INDEX = 3'h2,
    ACC_XMOVE_POINTER = 3'h3,
    ACC_FETCH = 3'h4
  } acc_kind_t;

  typedef struct packed {
    acc_kind_t kind;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } req_t;

  typedef enum logic [4:0] {
    BUS_IDLE = 5'b00001,
    BUS_ROM = 5'b00010,
    BUS_WAIT = 5'b00100,
    BUS_ADDR = 5'b01000,
    BUS_STRB = 5'b10000
  } bus_state_t;

  typedef enum logic [2:0] {
    LOCK_CLOSED = 3'b001,
    LOCK_KEY1 = 3'b010,
    LOCK_OPEN = 3'b100
  } lock_state_t;

endpackage

// File: design/data_memory_access_decode.sv
// scratchpad, aux RAM and external bus access decode
`timescale 1ns/100ps
`include "mem_access_defines.svh"

module data_memory_access_decode (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic resetPin,
  // core access request and answer
  input wire logic reqValid,
  input wire mem_access_pkg::req_t req,
  output logic reqReady,
  output logic rspValid,
  output logic rspMiss,
  output logic [7:0] rspData,
  // special function register port
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  // internal program memory
  output logic [15:0] romAddr,
  input wire logic [7:0] romData,
  // external bus pins
  input wire logic externalFetchSelectN,
  output logic programStoreStrobeN,
  output logic addressLatchStrobe,
  output logic [7:0] lowAddressDataPortOut,
  output logic lowAddressDataPortOe,
  input wire logic [7:0] lowAddressDataPortIn,
  output logic [7:0] upperAddressPortOut,
  output logic upperAddressPortOe,
  output logic writeStrobeN,
  output logic readStrobeN
);

  // ==========================================
  // state
  mem_access_pkg::bus_state_t state, next_state;
  mem_access_pkg::lock_state_t lock, next_lock;
  logic [2:0] phase;
  logic [4:0] holdCount;
  logic [7:0] auxHigh;
  logic [7:0] chipCtrl;
  logic [15:0] curAddr;
  logic [7:0] curWdata;
  logic curWrite;
  logic curFetch;
  logic [7:0] scratch [0:`ACC_SCRATCH_WORDS-1];
  logic [7:0] aux [0:`ACC_AUX_WORDS-1];

  // ==========================================
  // pin reset qualification
  wire pinReset = (holdCount == `ACC_RESET_HOLD);
  wire [4:0] next_holdCount =
    !resetPin ? 5'h00 : pinReset ? holdCount : 5'(holdCount + 5'h01);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      holdCount <= 5'h00;
    end else begin
      holdCount <= next_holdCount;
    end
  end

  // ==========================================
  // request decode
  wire isFetch = (req.kind == mem_access_pkg::ACC_FETCH);
  wire isExtMove = (req.kind == mem_access_pkg::ACC_XMOVE_INDEX) ||
                   (req.kind == mem_access_pkg::ACC_XMOVE_POINTER);
  wire auxEnable = chipCtrl[`ACC_AUX_EN_BIT];
  wire [15:0] moveAddr = (req.kind == mem_access_pkg::ACC_XMOVE_INDEX) ?
    {auxHigh, req.addr[7:0]} : req.addr;
  wire auxHit = isExtMove && (moveAddr <= `ACC_AUX_LAST) &&
                auxEnable;
  wire extData = isExtMove && !auxHit;
  // direct addresses at 80h and up belong to the register space
  wire directHit = (req.kind == mem_access_pkg::ACC_DIRECT) &&
                   (req.addr[7:0] < `ACC_DIRECT_LIMIT);
  wire indirectHit = (req.kind == mem_access_pkg::ACC_INDIRECT);
  wire scratchHit = directHit || indirectHit;
  wire extFetch = isFetch && !externalFetchSelectN;
  wire accept = reqValid && reqReady;
  wire phaseLast = (phase == `ACC_PHASE_LAST);
  wire [15:0] busAddr = isFetch ? req.addr : moveAddr;

  assign reqReady = (state == mem_access_pkg::BUS_IDLE) && !pinReset;

  // ==========================================
  // bus sequencer
  always_comb begin
    next_state = state;
    case (state)
      mem_access_pkg::BUS_IDLE: begin
        if (accept && isFetch && !extFetch) begin
          next_state = mem_access_pkg::BUS_ROM;
        end else if (accept && (extFetch || extData)) begin
          next_state = mem_access_pkg::BUS_WAIT;
        end
      end
      mem_access_pkg::BUS_ROM: begin
        next_state = mem_access_pkg::BUS_IDLE;
      end
      mem_access_pkg::BUS_WAIT: begin
        // line up with the free running latch strobe
        if (phaseLast) begin
          next_state = mem_access_pkg::BUS_ADDR;
        end
      end
      mem_access_pkg::BUS_ADDR: begin
        if (phase == 3'(`ACC_ALE_HIGH - 3'h1)) begin
          next_state = mem_access_pkg::BUS_STRB;
        end
      end
      mem_access_pkg::BUS_STRB: begin
        if (phaseLast) begin
          next_state = mem_access_pkg::BUS_IDLE;
        end
      end
      default: begin
        next_state = mem_access_pkg::BUS_IDLE;
      end
    endcase
    if (pinReset) begin
      next_state = mem_access_pkg::BUS_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= mem_access_pkg::BUS_IDLE;
      phase <= 3'h0;
    end else begin
      state <= next_state;
      phase <= phaseLast ? 3'h0 : 3'(phase + 3'h1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      curAddr <= 16'h0000;
      curWdata <= 8'h00;
      curWrite <= 1'b0;
      curFetch <= 1'b0;
      romAddr <= 16'h0000;
    end else if (accept) begin
      curAddr <= busAddr;
      curWdata <= req.wdata;
      curWrite <= req.write && !isFetch;
      curFetch <= isFetch;
      romAddr <= req.addr;
    end
  end

  // ==========================================
  // on-chip memories: no strobes or enables on the pins, but the address and data outputs follow the access
  always_ff @(posedge sys_clk) begin
    if (accept && scratchHit && req.write) begin
      scratch[req.addr[7:0]] <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (accept && auxHit && req.write) begin
      aux[moveAddr[9:0]] <= req.wdata;
    end
  end

  // ==========================================
  // answer
  wire strbEnd = (state == mem_access_pkg::BUS_STRB) && phaseLast;
  wire romEnd = (state == mem_access_pkg::BUS_ROM);
  wire localDone = accept && !isFetch && !extData;
  wire next_rspValid = localDone || romEnd || strbEnd;
  wire next_rspMiss = accept && !scratchHit && !isExtMove && !isFetch;
  wire [7:0] next_rspData =
    romEnd ? romData :
    strbEnd ? (curWrite ? 8'h00 : lowAddressDataPortIn) :
    scratchHit ? scratch[req.addr[7:0]] :
    auxHit ? aux[moveAddr[9:0]] : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rspValid <= 1'b0;
      rspMiss <= 1'b0;
      rspData <= 8'h00;
    end else begin
      rspValid <= next_rspValid;
      rspMiss <= next_rspMiss;
      if (next_rspValid) begin
        rspData <= next_rspData;
      end
    end
  end

  // ==========================================
  // pins, all registered so the bus sees no decode glitches
  wire inAddr = (state == mem_access_pkg::BUS_ADDR);
  wire inStrb = (state == mem_access_pkg::BUS_STRB);
  wire next_ale = (phase < `ACC_ALE_HIGH);
  wire next_lowOe = inAddr || (inStrb && curWrite);
  wire [7:0] next_lowOut = inAddr ? curAddr[7:0] : curWdata;
  wire next_upperOe = inAddr || inStrb;
  wire next_progStrobeN = !(inStrb && curFetch);
  wire next_rdN = !(inStrb && !curFetch && !curWrite);
  wire next_wrN = !(inStrb && curWrite);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addressLatchStrobe <= 1'b0;
      lowAddressDataPortOe <= 1'b0;
      lowAddressDataPortOut <= 8'h00;
      upperAddressPortOe <= 1'b0;
      upperAddressPortOut <= 8'h00;
      programStoreStrobeN <= 1'b1;
      readStrobeN <= 1'b1;
      writeStrobeN <= 1'b1;
    end else begin
      addressLatchStrobe <= next_ale;
      lowAddressDataPortOe <= next_lowOe;
      lowAddressDataPortOut <= next_lowOut;
      upperAddressPortOe <= next_upperOe;
      upperAddressPortOut <= curAddr[15:8];
      programStoreStrobeN <= next_progStrobeN;
      readStrobeN <= next_rdN;
      writeStrobeN <= next_wrN;
    end
  end

  // ==========================================
  // register port
  wire hitAuxHigh = (sfrAddr == `ACC_SFR_AUX_HIGH);
  wire hitChip = (sfrAddr == `ACC_SFR_CHIP_CTRL);
  wire wrUnlock = sfrWrite && (sfrAddr == `ACC_SFR_UNLOCK);
  // chip control only takes a write while the unlock sequence is open
  wire wrChip = sfrWrite && hitChip &&
                (lock == mem_access_pkg::LOCK_OPEN);
  wire [7:0] next_sfrRdata =
    hitAuxHigh ? auxHigh :
    hitChip ? (chipCtrl & `ACC_CHIP_CTRL_MASK) : 8'h00;

  always_comb begin
    next_lock = lock;
    if (wrUnlock) begin
      case (sfrWdata)
        `ACC_UNLOCK_KEY1: begin
          next_lock = mem_access_pkg::LOCK_KEY1;
        end
        `ACC_UNLOCK_KEY2: begin
          next_lock = (lock == mem_access_pkg::LOCK_KEY1) ?
            mem_access_pkg::LOCK_OPEN : mem_access_pkg::LOCK_CLOSED;
        end
        default: begin
          next_lock = mem_access_pkg::LOCK_CLOSED;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock <= mem_access_pkg::LOCK_CLOSED;
      auxHigh <= 8'h00;
      chipCtrl <= `ACC_CHIP_CTRL_RESET;
      sfrRdata <= 8'h00;
    end else if (pinReset) begin
      lock <= mem_access_pkg::LOCK_CLOSED;
      auxHigh <= 8'h00;
      chipCtrl <= `ACC_CHIP_CTRL_RESET;
      sfrRdata <= 8'h00;
    end else begin
      lock <= next_lock;
      if (sfrWrite && hitAuxHigh) begin
        auxHigh <= sfrWdata;
      end
      if (wrChip) begin
        chipCtrl <= sfrWdata & `ACC_CHIP_CTRL_MASK;
      end
      if (sfrRead) begin
        sfrRdata <= next_sfrRdata;
      end
    end
  end

endmodule

// File: bench/ext_mem_model.sv
// external program memory, data memory and address latch model
`timescale 1ns/100ps
module ext_mem_model (
  // clock
  input wire logic sys_clk,
  // bus pins from the block
  input wire logic ale,
  input wire logic psN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic lowOe,
  input wire logic [7:0] lowOut,
  input wire logic [7:0] upperOut,
  // value seen on the multiplexed port
  output logic [7:0] lowIn
);
  logic [7:0] lowLatch = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] sram [65536];
  wire [15:0] addr = {upperOut, lowLatch};
  // open drain, no pull: an idle port must not look like a stale byte
  assign lowIn = lowOe ? lowOut : !rdN ? sram[addr] :
    !psN ? lowLatch ^ 8'h5a : ~last;
  always_ff @(posedge sys_clk) begin
    last <= lowIn;
    if (ale && lowOe) lowLatch <= lowOut;
    if (!wrN) sram[addr] <= lowOut;
  end
endmodule

// File: bench/data_memory_access_decode_assertions.sv
// port assertions for the memory access decode block
`timescale 1ns/100ps
module data_memory_access_decode_assertions (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic resetPin,
  // core port
  input wire logic reqValid,
  input wire mem_access_pkg::req_t req,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire logic rspMiss,
  input wire logic [7:0] rspData,
  // bus pins
  input wire logic externalFetchSelectN,
  input wire logic programStoreStrobeN,
  input wire logic addressLatchStrobe,
  input wire logic lowAddressDataPortOe,
  input wire logic [7:0] upperAddressPortOut,
  input wire logic upperAddressPortOe,
  input wire logic writeStrobeN,
  input wire logic readStrobeN
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] pinHigh;
  wire take = reqValid && reqReady;
  wire fetch = req.kind == mem_access_pkg::ACC_FETCH;
  wire extMove = req.kind inside {mem_access_pkg::ACC_XMOVE_INDEX,
    mem_access_pkg::ACC_XMOVE_POINTER};
  wire scratchKind = req.kind inside {mem_access_pkg::ACC_DIRECT,
    mem_access_pkg::ACC_INDIRECT};
  wire dirHigh = req.kind == mem_access_pkg::ACC_DIRECT && req.addr[7];
  wire anyStrobe = !readStrobeN || !writeStrobeN || !programStoreStrobeN;
  // saturating count of consecutive reset pin highs
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) pinHigh <= 5'h00;
    else pinHigh <= !resetPin ? 5'h00 : pinHigh + 5'(pinHigh != 5'h1f);
  property p_ale_rate;
    $rose(addressLatchStrobe) |=> addressLatchStrobe ##1
      !addressLatchStrobe [*4] ##1 addressLatchStrobe;
  endproperty
  a_ale_rate: assert property (p_ale_rate)
    else $error("latch strobe not one in six");
  property p_int_fetch;
    take && fetch && externalFetchSelectN |=>
      (programStoreStrobeN && !lowAddressDataPortOe) [*2];
  endproperty
  a_int_fetch: assert property (p_int_fetch)
    else $error("internal fetch touched the bus");
  property p_ext_fetch;
    take && fetch && !externalFetchSelectN |-> ##[2:13] !programStoreStrobeN;
  endproperty
  a_ext_fetch: assert property (p_ext_fetch)
    else $error("external fetch gave no program strobe");
  property p_upper;
    anyStrobe |-> upperAddressPortOe && $stable(upperAddressPortOut);
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper address not held during strobe");
  property p_local;
    take && scratchKind |=> rspValid && rspMiss == $past(dirHigh);
  endproperty
  a_local: assert property (p_local)
    else $error("scratchpad answer wrong");
  property p_miss_data;
    rspValid && rspMiss |-> rspData == 8'h00;
  endproperty
  a_miss_data: assert property (p_miss_data)
    else $error("refused access returned data");
  property p_aux_quiet;
    take && extMove ##1 rspValid |-> $stable(upperAddressPortOut) and
      (readStrobeN && writeStrobeN && !lowAddressDataPortOe &&
      !upperAddressPortOe) [*2];
  endproperty
  a_aux_quiet: assert property (p_aux_quiet)
    else $error("aux access disturbed the bus");
  property p_ext_move;
    take && extMove ##1 !rspValid |-> ##[7:12] rspValid;
  endproperty
  a_ext_move: assert property (p_ext_move)
    else $error("external move answer late");
  property p_reset_pin;
    resetPin && pinHigh >= 5'h18 |-> !reqReady;
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("reset pin held but requests accepted");
endmodule

bind data_memory_access_decode data_memory_access_decode_assertions u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .resetPin(resetPin),
  .reqValid(reqValid), .req(req), .reqReady(reqReady),
  .rspValid(rspValid), .rspMiss(rspMiss), .rspData(rspData),
  .externalFetchSelectN(externalFetchSelectN),
  .programStoreStrobeN(programStoreStrobeN),
  .addressLatchStrobe(addressLatchStrobe),
  .lowAddressDataPortOe(lowAddressDataPortOe),
  .upperAddressPortOut(upperAddressPortOut),
  .upperAddressPortOe(upperAddressPortOe),
  .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN));

// File: bench/test_data_memory_access_decode.sv
// self-checking bench for the memory access decode block
`timescale 1ns/100ps
module test_data_memory_access_decode;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic resetPin = 1'b0;
  logic reqValid = 1'b0;
  mem_access_pkg::req_t req = '0;
  logic sfrWrite = 1'b0;
  logic sfrRead = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWdata = 8'h00;
  logic extN = 1'b1;
  logic reqReady, rspValid, rspMiss, psN, ale, lowOe, upperOe, wrN, rdN;
  logic [7:0] rspData, sfrRdata, lowOut, lowIn, upperOut;
  logic [15:0] romAddr;
  wire [7:0] romData = romAddr[7:0] ^ 8'h3c;
  int nFail = 0;
  int comparisons = 0;

  data_memory_access_decode u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .resetPin(resetPin), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .rspValid(rspValid), .rspMiss(rspMiss),
    .rspData(rspData), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
    .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .romAddr(romAddr), .romData(romData), .externalFetchSelectN(extN),
    .programStoreStrobeN(psN), .addressLatchStrobe(ale),
    .lowAddressDataPortOut(lowOut), .lowAddressDataPortOe(lowOe),
    .lowAddressDataPortIn(lowIn), .upperAddressPortOut(upperOut),
    .upperAddressPortOe(upperOe), .writeStrobeN(wrN), .readStrobeN(rdN));
  ext_mem_model u_mem (.sys_clk(sys_clk), .ale(ale), .psN(psN),
    .rdN(rdN), .wrN(wrN), .lowOe(lowOe), .lowOut(lowOut),
    .upperOut(upperOut), .lowIn(lowIn));

  initial forever #20 sys_clk = ~sys_clk;

  // ==========================================
  // tasks
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, nFail);
    if (nFail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, e);
    comparisons++;
    if (g !== e) begin
      nFail++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic sw(input logic [7:0] a, d);
    @(negedge sys_clk);
    sfrWrite = 1'b1;
    sfrAddr = a;
    sfrWdata = d;
    @(negedge sys_clk);
    sfrWrite = 1'b0;
  endtask
  task automatic sr(input logic [7:0] a, e);
    @(negedge sys_clk);
    sfrRead = 1'b1;
    sfrAddr = a;
    @(negedge sys_clk);
    sfrRead = 1'b0;
    chk(sfrRdata, e);
  endtask
  task automatic unlock;
    sw(8'hf6, 8'h87);
    sw(8'hf6, 8'h59);
  endtask
  // one core request, held until taken, then the answer checked
  task automatic acc(input mem_access_pkg::acc_kind_t k, input logic w,
      input logic [15:0] a, input logic [7:0] d, e, input logic m);
    int i;
    @(negedge sys_clk);
    reqValid = 1'b1;
    req = '{k, w, a, d};
    for (i = 0; i < 40 && reqReady !== 1'b1; i++) @(negedge sys_clk);
    @(negedge sys_clk);
    reqValid = 1'b0;
    for (i = 0; i < 20 && rspValid !== 1'b1; i++) @(negedge sys_clk);
    chk({7'h00, rspValid}, 8'h01);
    chk({7'h00, rspMiss}, {7'h00, m});
    if (!w) chk(rspData, e);
  endtask

  // ==========================================
  // tests
  initial begin
    repeat (5000) @(posedge sys_clk);
    nFail++;
    end_of_test();
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    sr(8'hf6, 8'h00);
    sw(8'hbf, 8'h10);
    sr(8'hbf, 8'h00);
    acc(mem_access_pkg::ACC_XMOVE_POINTER, 1, 16'h0134, 8'hc3, 0, 0);
    unlock();
    sw(8'hbf, 8'h10);
    sw(8'hf6, 8'h00);
    sr(8'hbf, 8'h10);
    sw(8'ha1, 8'h01);
    sr(8'ha1, 8'h01);
    acc(mem_access_pkg::ACC_XMOVE_INDEX, 1, 16'h0023, 8'h55, 0, 0);
    acc(mem_access_pkg::ACC_XMOVE_POINTER, 0, 16'h0123, 0, 8'h55, 0);
    acc(mem_access_pkg::ACC_XMOVE_POINTER, 1, 16'h0134, 8'h78, 0, 0);
    acc(mem_access_pkg::ACC_XMOVE_POINTER, 0, 16'h0134, 0, 8'h78, 0);
    acc(mem_access_pkg::ACC_XMOVE_POINTER, 1, 16'h7fff, 8'ha5, 0, 0);
    acc(mem_access_pkg::ACC_XMOVE_POINTER, 0, 16'h7fff, 0, 8'ha5, 0);
    acc(mem_access_pkg::ACC_DIRECT, 1, 16'h0012, 8'h5a, 0, 0);
    acc(mem_access_pkg::ACC_INDIRECT, 0, 16'h0012, 0, 8'h5a, 0);
    acc(mem_access_pkg::ACC_INDIRECT, 1, 16'h0090, 8'hc6, 0, 0);
    acc(mem_access_pkg::ACC_INDIRECT, 0, 16'h0090, 0, 8'hc6, 0);
    acc(mem_access_pkg::ACC_DIRECT, 0, 16'h0090, 0, 8'h00, 1);
    acc(mem_access_pkg::ACC_FETCH, 0, 16'h0042, 0, 8'h7e, 0);
    @(negedge sys_clk);
    extN = 1'b0;
    acc(mem_access_pkg::ACC_FETCH, 0, 16'h1234, 0, 8'h6e, 0);
    @(negedge sys_clk);
    extN = 1'b1;
    unlock();
    sw(8'hbf, 8'h00);
    sw(8'hf6, 8'h00);
    acc(mem_access_pkg::ACC_XMOVE_POINTER, 0, 16'h0134, 0, 8'hc3, 0);
    // hold the pin past two machine cycles of twelve clocks
    resetPin = 1'b1;
    repeat (30) @(negedge sys_clk);
    resetPin = 1'b0;
    sr(8'ha1, 8'h00);
    sr(8'hbf, 8'h00);
    end_of_test();
  end
endmodule
